// File: sar_readout_pkg.sv
// Shared constants and types for the converter control and serial readout
package sar_readout_pkg;

   // Result word
   localparam int RESULT_BITS   = 16;
   localparam int BITS_PER_STEP = 2;
   localparam int SAR_STEPS     = RESULT_BITS / BITS_PER_STEP;
   localparam logic [3:0] LAST_STEP = 4'(SAR_STEPS - 1);

   // Chain delay in serial clock cycles
   localparam int CHAIN_DELAY = 16;
   localparam logic [4:0] LAST_BIT_COUNT = 5'(CHAIN_DELAY);

   // Timing
   localparam int CLK_PERIOD_NS    = 40;
   localparam int FAST_PERIOD_NS   = 400;
   localparam int NORMAL_PERIOD_NS = 500;
   localparam int FAST_CYCLES =
      (FAST_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NORMAL_CYCLES =
      (NORMAL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [5:0] FAST_GAP   = 6'(FAST_CYCLES);
   localparam logic [5:0] NORMAL_GAP = 6'(NORMAL_CYCLES);
   localparam logic [5:0] GAP_MAX    = 6'h3F;

   // Register bus
   localparam int ADDR_BITS = 4;
   localparam logic [3:0] OFS_STATUS  = 4'h0;
   localparam logic [3:0] OFS_IRQ_EN  = 4'h1;
   localparam logic [3:0] OFS_IRQ_CLR = 4'h2;
   localparam logic [3:0] OFS_RESULT  = 4'h3;
   localparam logic [3:0] OFS_MODE    = 4'h4;

   // Event bit positions in status, enable and clear
   localparam int EV_CONV_DONE  = 0;
   localparam int EV_READ_DONE  = 1;
   localparam int EV_START_LOST = 2;
   localparam int EV_BITS       = 3;

   // Mode register bit positions
   localparam int MODE_CHAIN    = 0;
   localparam int MODE_BUSY_EN  = 1;
   localparam int MODE_FAST     = 2;
   localparam int MODE_ACTIVE   = 3;
   localparam int MODE_FIRST    = 4;

   // Values after reset
   localparam logic [2:0]  STATUS_RESET = 3'h0;
   localparam logic [2:0]  IRQ_EN_RESET = 3'h0;
   localparam logic [15:0] RESULT_RESET = 16'h0000;

   typedef enum logic [1:0] {
      ACQUIRE,
      CONVERT
   } conv_state_t;

endpackage

// File: two_stage_sync.sv
// Two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module two_stage_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } sync_t;

   sync_t st;
   sync_t next_st;

   always_comb
   begin
      next_st.first  = asyncIn;
      next_st.second = st.first;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign syncOut = st.second;

endmodule // two_stage_sync

// File: sar_adc_serial_readout.sv
// Conversion control, mode selection and serial readout of the converter
//
// Operation
// - result leaves on serial_data_out, changing on falling serial clock edges.
// - while selected each serial clock shifts out one result bit.
// - convert_start rising starts a conversion and latches the mode.
// - serial_data_in low at that edge selects chain mode.
// - serial_data_in high at that edge selects select mode.
// - select mode drives output when either input low, else off.
// - chain mode passes serial_data_in to output 16 clocks later.
// - either input low at completion enables the busy indicator.
// - fast mode allows 2.5 MSPS and stays powered between conversions.
// - slow mode caps at 2.0 MSPS and powers down between conversions.
// - conversions run from the own clock, no serial clock needed.
// - completion returns to acquisition with code, and with busy indicator when enabled.
`timescale 1ns/1ps
module sar_adc_serial_readout
   import sar_readout_pkg::*;
(
   input  wire logic                             ref_clk,
   input  wire logic                             rst,
   input  wire logic                             convert_start,
   input  wire logic                             serial_data_in,
   input  wire logic                             serial_clock,
   input  wire logic                             fast_mode_select,
   input  wire logic [sar_readout_pkg::RESULT_BITS-1:0] analogCode,
   output logic                                  serial_data_out,
   output logic                                  serial_data_out_en,
   output logic                                  powerDown,
   output logic                                  sampleHold,
   input  wire logic [sar_readout_pkg::ADDR_BITS-1:0]   regAddr,
   input  wire logic [31:0]                      regWrData,
   input  wire logic                             regWr,
   input  wire logic                             regRd,
   output logic      [31:0]                      regRdData,
   output logic                                  irq
);

   import sar_readout_pkg::*;

   typedef struct packed {
      conv_state_t              state;
      logic                     chainMode;
      logic                     busyEn;
      logic [RESULT_BITS-1:0]   held;
      logic [RESULT_BITS-1:0]   trial;
      logic [3:0]               step;
      logic [RESULT_BITS-1:0]   shifter;
      logic                     outBit;
      logic [4:0]               bitCount;
      logic                     loaded;
      logic [5:0]               gap;
      logic [EV_BITS-1:0]       status;
      logic [EV_BITS-1:0]       irqEn;
      logic [RESULT_BITS-1:0]   result;
      logic [31:0]              rdData;
      logic                     prevCnv;
      logic                     prevSck;
      logic                     prevFast;
      logic                     firstFast;
   } core_t;

   core_t st;
   core_t next_st;

   logic [3:0] pinSync;
   logic       cnvS;
   logic       sdiS;
   logic       sckS;
   logic       fastS;

   // Pins come from the host's domain and are resynchronised together
   two_stage_sync #(
      .WIDTH   (4)
   ) pinSyncer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .asyncIn ({fast_mode_select, serial_clock, serial_data_in,
                 convert_start}),
      .syncOut (pinSync)
   );

   assign cnvS  = pinSync[0];
   assign sdiS  = pinSync[1];
   assign sckS  = pinSync[2];
   assign fastS = pinSync[3];

   // Resolves two result bits per internal clock cycle
   function automatic logic [RESULT_BITS-1:0] sarStep(
      input logic [RESULT_BITS-1:0] trialIn,
      input logic [RESULT_BITS-1:0] target,
      input logic [3:0]             stepIn
   );
      logic [RESULT_BITS-1:0] work;
      logic [RESULT_BITS-1:0] probe;
      int                     pos;
      work = trialIn;
      for (int k = 0; k < BITS_PER_STEP; k++)
      begin
         pos   = RESULT_BITS - 1 - BITS_PER_STEP * int'(stepIn) - k;
         probe = work | (RESULT_BITS'(1) << pos);
         if (probe <= target)
         begin
            work = probe;
         end
      end
      return work;
   endfunction

   function automatic logic isAddr(
      input logic [ADDR_BITS-1:0] addr,
      input logic [ADDR_BITS-1:0] ofs
   );
      return addr == ofs;
   endfunction

   logic                   cnvRise;
   logic                   sckFall;
   logic [5:0]             needGap;
   logic [EV_BITS-1:0]     events;
   logic [EV_BITS-1:0]     clrMask;
   logic                   selected;

   always_comb
   begin
      next_st  = st;
      events   = '0;
      clrMask  = '0;
      cnvRise  = cnvS && !st.prevCnv;
      sckFall  = !sckS && st.prevSck;
      needGap  = fastS ? FAST_GAP : NORMAL_GAP;
      if (!fastS)
      begin
         needGap = NORMAL_GAP;
      end
      selected = st.chainMode || !(cnvS && sdiS);

      next_st.prevCnv  = cnvS;
      next_st.prevSck  = sckS;
      next_st.prevFast = fastS;
      if (st.gap != GAP_MAX)
      begin
         next_st.gap = st.gap + 6'h01;
      end

      // Flag stands from turning on fast mode until the first conversion after it completes
      if (fastS && !st.prevFast)
      begin
         next_st.firstFast = 1'b1;
      end

      case (st.state)
         ACQUIRE:
         begin
            if (cnvRise)
            begin
               // Starts closer than the minimum period are dropped
               // Compared without the increment: gap idles at its
               // saturated top, where adding one would wrap to zero
               if (st.gap >= needGap - 6'h01)
               begin
                  next_st.state     = CONVERT;
                  next_st.chainMode = !sdiS;
                  if (sdiS)
                  begin
                     next_st.chainMode = 1'b0;
                  end
                  next_st.held    = analogCode;
                  next_st.trial   = '0;
                  next_st.step    = 4'h0;
                  next_st.gap     = 6'h00;
                  next_st.loaded  = 1'b0;
                  next_st.outBit  = 1'b1;
                  next_st.busyEn  = 1'b0;
               end
               else
               begin
                  events[EV_START_LOST] = 1'b1;
               end
            end
            else if (st.loaded && sckFall && (selected || st.chainMode))
            begin
               // Shift on the falling edge so the host samples just before the next fall
               next_st.outBit  = st.shifter[RESULT_BITS-1];
               next_st.shifter = {st.shifter[RESULT_BITS-2:0],
                                  st.chainMode ? sdiS : 1'b0};
               if (st.bitCount != LAST_BIT_COUNT)
               begin
                  next_st.bitCount = st.bitCount + 5'h01;
                  if (st.bitCount + 5'h01 == LAST_BIT_COUNT)
                  begin
                     events[EV_READ_DONE] = 1'b1;
                  end
               end
            end
         end
         CONVERT:
         begin
            // Runs on ref_clk alone; serial clock plays no part here
            next_st.trial = sarStep(st.trial, st.held, st.step);
            next_st.step  = st.step + 4'h1;
            if (st.step == LAST_STEP)
            begin
               next_st.state    = ACQUIRE;
               next_st.result   = next_st.trial;
               next_st.busyEn   = !sdiS || !cnvS;
               next_st.loaded   = 1'b1;
               next_st.bitCount = 5'h00;
               events[EV_CONV_DONE] = 1'b1;
               if (!sdiS || !cnvS)
               begin
                  // Busy indicator: a low bit ahead of the data word
                  next_st.outBit  = 1'b0;
                  next_st.shifter = next_st.trial;
               end
               else
               begin
                  next_st.outBit  = next_st.trial[RESULT_BITS-1];
                  next_st.shifter = {next_st.trial[RESULT_BITS-2:0],
                                     st.chainMode ? sdiS : 1'b0};
               end
            end
         end
         default:
         begin
            next_st.state = ACQUIRE;
         end
      endcase

      if (events[EV_CONV_DONE] && st.firstFast)
      begin
         next_st.firstFast = 1'b0;
      end

      // Register writes
      if (regWr && isAddr(regAddr, OFS_IRQ_EN))
      begin
         next_st.irqEn = regWrData[EV_BITS-1:0];
      end
      if (regWr && isAddr(regAddr, OFS_IRQ_CLR))
      begin
         clrMask = regWrData[EV_BITS-1:0];
      end
      // A new event in the clearing cycle survives the clear
      next_st.status = (st.status & ~clrMask) | events;

      // Register reads, answered one cycle later
      next_st.rdData = 32'h0000_0000;
      if (regRd)
      begin
         case (regAddr)
            OFS_STATUS:
            begin
               next_st.rdData = {29'h0, st.status};
            end
            OFS_IRQ_EN:
            begin
               next_st.rdData = {29'h0, st.irqEn};
            end
            OFS_RESULT:
            begin
               next_st.rdData = {16'h0000, st.result};
            end
            OFS_MODE:
            begin
               next_st.rdData = 32'h0000_0000;
               next_st.rdData[MODE_CHAIN]   = st.chainMode;
               next_st.rdData[MODE_BUSY_EN] = st.busyEn;
               next_st.rdData[MODE_FAST]    = fastS;
               next_st.rdData[MODE_ACTIVE]  = st.state == CONVERT;
               next_st.rdData[MODE_FIRST]   = st.firstFast;
            end
            default:
            begin
               next_st.rdData = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st          <= '0;
         st.state    <= ACQUIRE;
         st.gap      <= GAP_MAX;
         st.status   <= STATUS_RESET;
         st.irqEn    <= IRQ_EN_RESET;
         st.result   <= RESULT_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign serial_data_out    = st.outBit;
   assign serial_data_out_en = st.chainMode || !(cnvS && sdiS);
   // Slow mode parks the analog core whenever no conversion runs
   assign powerDown  = !fastS && (st.state != CONVERT);
   assign sampleHold = st.state == CONVERT;
   assign regRdData  = st.rdData;
   assign irq        = |(st.status & st.irqEn);

endmodule // sar_adc_serial_readout

// File: sar_readout_asserts.sv
// Port timing checks for the converter readout block
`timescale 1ns/1ps
module sar_readout_asserts (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        convert_start,
   input wire logic        serial_data_in,
   input wire logic        serial_clock,
   input wire logic        fast_mode_select,
   input wire logic        serial_data_out,
   input wire logic        serial_data_out_en,
   input wire logic        powerDown,
   input wire logic        sampleHold,
   input wire logic        regRd,
   input wire logic [31:0] regRdData
);
   logic [5:0] clkHist;

   // Pins reach the core through two flops, so look a few samples back
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         clkHist <= 6'h00;
      else
         clkHist <= {clkHist[4:0], serial_clock};

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   conv_length_a: assert property (
      $rose(sampleHold) |-> sampleHold [*8] ##1 !sampleHold)
      else $error("conversion length wrong");
   start_cause_a: assert property (
      $rose(sampleHold) |-> $past(convert_start) &&
         !$past(convert_start, 6))
      else $error("conversion without convert rise");
   shift_on_fall_a: assert property (
      $changed(serial_data_out) |-> sampleHold || $past(sampleHold) ||
         (|(clkHist[5:1] & ~clkHist[4:0])))
      else $error("output moved without serial clock fall");
   drive_when_low_a: assert property (
      (!convert_start || !serial_data_in) [*4] |-> serial_data_out_en)
      else $error("output not driven");
   fast_awake_a: assert property (
      fast_mode_select [*4] |-> !powerDown)
      else $error("powered down in fast mode");
   slow_sleep_a: assert property (
      !fast_mode_select [*4] ##0 !sampleHold |-> powerDown)
      else $error("awake between slow conversions");
   awake_convert_a: assert property (
      $rose(sampleHold) |-> !powerDown [*8])
      else $error("powered down while converting");
   read_idle_a: assert property (
      !$past(regRd) |-> regRdData == 32'h0)
      else $error("read data outside its cycle");

   cover property ($rose(sampleHold));
   cover property ($fell(serial_data_out_en));
   cover property ($fell(powerDown));
endmodule // sar_readout_asserts

bind sar_adc_serial_readout sar_readout_asserts chk (.*);

// File: host_model.sv
// Host side model: convert pulses and serial clock frames
`timescale 1ns/1ps
module host_model (
   input  wire logic ref_clk,
   input  wire logic serial_data_out,
   input  wire logic serial_data_out_en,
   output logic      convert_start,
   output logic      serial_data_in,
   output logic      serial_clock
);
   // A released output shows the inverse so stale data never passes
   wire logic sdoLine = serial_data_out_en ? serial_data_out
                                           : !serial_data_out;

   initial
   begin
      convert_start = 1'b0;
      serial_data_in = 1'b1;
      serial_clock = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // Keep high holds convert up for a chain readout
   task automatic start(input logic mode, input logic sdiAfter,
                        input int hi, input logic keep);
      @(posedge ref_clk);
      convert_start <= 1'b0;
      serial_data_in <= mode;
      wait_clk(6);
      convert_start <= 1'b1;
      wait_clk(4);
      serial_data_in <= sdiAfter;
      wait_clk(hi);
      convert_start <= keep;
   endtask

   // Clock stands low between frames; data taken just before each fall
   task automatic frame(input int n, input logic [31:0] din,
                        output logic [31:0] got);
      got = 32'h0;
      for (int i = 0; i < n; i++)
      begin
         @(posedge ref_clk);
         serial_clock <= 1'b1;
         serial_data_in <= din[31-i];
         wait_clk(3);
         got = {got[30:0], sdoLine};
         @(posedge ref_clk);
         serial_clock <= 1'b0;
         wait_clk(3);
      end
   endtask
endmodule // host_model

// File: testbench.sv
// Self-checking bench for the converter readout block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %h want %h", $time, a, e); end end
module testbench;
   import sar_readout_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        fast_mode_select = 1'b0;
   logic [15:0] analogCode = 16'h0000;
   logic [3:0]  regAddr = 4'h0;
   logic [31:0] regWrData = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdData;
   logic        convert_start;
   logic        serial_data_in;
   logic        serial_clock;
   logic        serial_data_out;
   logic        serial_data_out_en;
   logic        powerDown;
   logic        sampleHold;
   logic        irq;
   int          num_errors = 0;
   int          checks = 0;
   int          seed = 47686;
   logic [31:0] got;
   logic [31:0] rd;
   logic [31:0] din;
   logic [15:0] code;

   sar_adc_serial_readout dut (.*);
   host_model host (.*);

   always #20 ref_clk = ~ref_clk;

   // The stage filled at completion holds the high input level that
   // kept the busy bit off; chained bits follow it
   function automatic logic [31:0] chain_exp(input logic [15:0] c,
                                             input logic [31:0] d);
      return {c, 1'b1, d[31:17]};
   endfunction

   task automatic clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rdv(input logic [3:0] a);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      @(negedge ref_clk);
      rd = regRdData;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      rdv(a);
      `CHK(rd, e)
   endtask

   task automatic convert(input logic mode, input int hi,
                          input logic keep, input int n);
      @(posedge ref_clk);
      code = 16'($random(seed));
      din = $random(seed);
      analogCode <= code;
      host.start(mode, 1'b1, hi, keep);
      clk(14);
      host.frame(n, din, got);
   endtask

   task automatic close_out;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #800000;
      num_errors++;
      close_out();
   end

   initial
   begin
      clk(2);
      rst <= 1'b0;
      rdc(OFS_STATUS, 32'h0);
      rdc(OFS_IRQ_EN, 32'h0);
      wr(OFS_RESULT, 32'hFFFF);
      wr(4'hF, 32'h7);
      rdc(OFS_RESULT, 32'h0);
      rdc(4'hF, 32'h0);
      rdc(OFS_IRQ_CLR, 32'h0);
      wr(OFS_IRQ_EN, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         fast_mode_select <= i[2];
         convert(!i[0], 14, i[0], i[0] ? 32 : 16);
         if (i != 4)
         begin
            if (i[0])
               `CHK(got, chain_exp(code, din))
            else
               `CHK(got[15:0], code)
         end
         rdv(OFS_RESULT);
         `CHK(rd[15:0], code)
         rdv(OFS_MODE);
         `CHK(rd[MODE_CHAIN], i[0])
         `CHK(rd[MODE_BUSY_EN], 1'b0)
         `CHK(irq, 1'b1)
         wr(OFS_IRQ_CLR, 32'h7);
         @(negedge ref_clk);
         `CHK(irq, 1'b0)
      end
      convert(1'b1, 1, 1'b0, 17);
      `CHK(got[16:0], {1'b0, code})
      rdv(OFS_MODE);
      `CHK(rd[MODE_BUSY_EN], 1'b1)
      host.start(1'b1, 1'b1, 14, 1'b1);
      @(negedge ref_clk);
      `CHK(serial_data_out_en, 1'b0)
      for (int f = 0; f < 2; f++)
      begin
         @(posedge ref_clk);
         fast_mode_select <= f[0];
         wr(OFS_IRQ_CLR, 32'h7);
         wr(OFS_IRQ_EN, 32'h4);
         host.start(1'b1, 1'b1, 1, 1'b0);
         host.start(1'b1, 1'b1, 1, 1'b0);
         clk(20);
         rdv(OFS_STATUS);
         `CHK(rd[EV_START_LOST], !f[0])
         `CHK(irq, !f[0])
         wr(OFS_IRQ_EN, 32'h0);
         @(negedge ref_clk);
         `CHK(irq, 1'b0)
      end
      close_out();
   end
endmodule // testbench
